//--- hdl/ldev_cfg_pkg.sv
// Constants for the logical device resource configuration bank
package ldev_cfg_pkg;
	localparam int          NUM_LDEV       = 8;
	localparam logic [7:0]  IDX_LDN        = 8'h07;
	localparam logic [7:0]  IDX_ACTIVATE   = 8'h30;
	localparam logic [7:0]  IDX_BASE_HI    = 8'h60;
	localparam logic [7:0]  IDX_BASE_LO    = 8'h61;
	localparam logic [7:0]  IDX_BASE2_HI   = 8'h62;
	localparam logic [7:0]  IDX_BASE2_LO   = 8'h63;
	localparam logic [7:0]  IDX_IRQ_SEL    = 8'h70;
	localparam logic [7:0]  IDX_DMA_SEL    = 8'h74;
	localparam logic [7:0]  IRQ_SEL_RESET  = 8'h00;
	localparam logic [7:0]  DMA_SEL_RESET  = 8'h04;
	localparam logic [15:0] BASE_RESET     = 16'h0000;
	localparam logic [2:0]  LDN_FLOPPY     = 3'h0;
	localparam logic [2:0]  LDN_PARPORT    = 3'h3;
	localparam logic [2:0]  LDN_UART1      = 3'h4;
	localparam logic [2:0]  LDN_UART2      = 3'h5;
	localparam logic [2:0]  LDN_KEYBOARD   = 3'h7;
	localparam logic [11:0] BASE_MIN       = 12'h100;
	localparam logic [11:0] BASE_MAX8      = 12'hFF8;
	localparam logic [11:0] BASE_MAX4      = 12'hFFC;
	localparam logic [11:0] ECP_OFS        = 12'h400;
	localparam logic [11:0] KBD_DATA_ADDR  = 12'h060;
	localparam logic [11:0] KBD_CMD_ADDR   = 12'h064;
	localparam logic [15:0] PAR_IRQ_MASK   = 16'h1CF8;
	localparam logic [3:0]  IRQ_SHARED     = 4'h2;
	localparam logic [2:0]  PMODE_ECP      = 3'h3;
	localparam logic [2:0]  PMODE_EPP      = 3'h4;
	localparam int          DMA_CH         = 3;
endpackage : ldev_cfg_pkg

//--- hdl/ldev_cfg.sv
// Per-logical-device configuration bank, I/O decode and IRQ/DMA routing
`timescale 1ns/10ps
module ldev_cfg
	import ldev_cfg_pkg::*;
(
	input  wire logic                    ref_clk,
	input  wire logic                    nrst,
	input  wire logic                    standby_por_n,
	input  wire logic                    cfg_state,
	input  wire logic                    cfg_wr,
	input  wire logic                    cfg_rd,
	input  wire logic [7:0]              cfg_index,
	input  wire logic [7:0]              cfg_wdata,
	output logic      [7:0]              cfg_rdata,
	input  wire logic [11:0]             io_addr,
	input  wire logic                    io_strobe,
	output logic      [7:0]              io_select,
	output logic                         ecp_select,
	output logic                         epp_allowed,
	input  wire logic                    serial_irq_mode,
	input  wire logic                    mgmt_irq_enable,
	input  wire logic [7:0]              unit_irq,
	input  wire logic [7:0]              unit_dma_req,
	input  wire logic                    floppy_dma_irq_enable,
	input  wire logic                    parport_irq_enable,
	input  wire logic                    ecp_service_interrupt_bit,
	input  wire logic                    ecp_dma_enable_bit,
	input  wire logic [2:0]              parport_mode,
	input  wire logic [3:0]              uart1_ier_bits,
	input  wire logic                    uart1_aux_output_two,
	input  wire logic [3:0]              uart2_ier_bits,
	input  wire logic                    uart2_aux_output_two,
	input  wire logic                    uart2_dma_enable,
	output logic      [15:0]             irq_out,
	output logic      [15:0]             irq_oe,
	output logic                         system_mgmt_interrupt_n,
	output logic      [ldev_cfg_pkg::DMA_CH:1] dma_request_pin,
	output logic      [ldev_cfg_pkg::DMA_CH:1] dma_request_oe
);
	import ldev_cfg_pkg::*;

	typedef struct packed {
		logic [2:0]                 ldn;
		logic [NUM_LDEV-1:0]        active;
		logic [NUM_LDEV-1:0][15:0]  base;
		logic [NUM_LDEV-1:0][15:0]  base2;
		logic [NUM_LDEV-1:0][3:0]   irq_lvl;
		logic [NUM_LDEV-1:0][2:0]   dma_sel;
	} state_s;

	state_s state_reg;
	state_s state_next;
	logic   uart2_act_reg;
	logic   uart2_act_next;

	// Window check for eight-byte windows
	function automatic logic win8_ok(input logic [15:0] b);
		win8_ok = (b[11:0] >= BASE_MIN) && (b[11:0] <= BASE_MAX8)
			&& (b[2:0] == 3'h0) && (b[15:12] == 4'h0);
	endfunction

	function automatic logic hit8(input logic [15:0] b,
		input logic [11:0] a);
		hit8 = (a[11:3] == b[11:3]);
	endfunction

	logic [NUM_LDEV-1:0] dev_on;
	logic                par_ok;
	logic                par8;
	logic                wr_ok;
	logic [7:0]          rd_mux;
	logic [7:0]          dev_irq;
	logic [7:0]          dev_dma;

	always_comb
	begin
		dev_on = state_reg.active;
		dev_on[LDN_UART2] = uart2_act_reg;
	end

	assign par8   = win8_ok(state_reg.base[LDN_PARPORT]);
	assign par_ok = (state_reg.base[LDN_PARPORT][11:0] >= BASE_MIN)
		&& (state_reg.base[LDN_PARPORT][11:0] <= BASE_MAX4)
		&& (state_reg.base[LDN_PARPORT][1:0] == 2'h0)
		&& (state_reg.base[LDN_PARPORT][15:12] == 4'h0);
	assign epp_allowed = par8;

	// Writes accepted only inside the configuration state
	assign wr_ok = cfg_wr && cfg_state;

	always_comb
	begin
		state_next     = state_reg;
		uart2_act_next = uart2_act_reg;
		if (wr_ok)
		begin
			if (cfg_index == IDX_LDN)
				state_next.ldn = cfg_wdata[2:0];
			else if (cfg_index == IDX_ACTIVATE)
			begin
				// One flop serves as both activate and power bit
				if (state_reg.ldn == LDN_UART2)
					uart2_act_next = cfg_wdata[0];
				else
					state_next.active[state_reg.ldn] = cfg_wdata[0];
			end
			else if (cfg_index == IDX_BASE_HI)
				state_next.base[state_reg.ldn][15:8] = cfg_wdata;
			else if (cfg_index == IDX_BASE_LO)
				state_next.base[state_reg.ldn][7:0] = cfg_wdata;
			else if (cfg_index == IDX_BASE2_HI && state_reg.ldn == LDN_UART2)
				state_next.base2[state_reg.ldn][15:8] = cfg_wdata;
			else if (cfg_index == IDX_BASE2_LO && state_reg.ldn == LDN_UART2)
				state_next.base2[state_reg.ldn][7:0] = cfg_wdata;
			else if (cfg_index == IDX_IRQ_SEL)
				state_next.irq_lvl[state_reg.ldn] = cfg_wdata[3:0];
			else if (cfg_index == IDX_DMA_SEL)
				state_next.dma_sel[state_reg.ldn] = cfg_wdata[2:0];
		end
	end

	// Register reads; unimplemented indices read zero
	always_comb
	begin
		rd_mux = 8'h00;
		if (cfg_index == IDX_LDN)
			rd_mux = {5'h00, state_reg.ldn};
		else if (cfg_index == IDX_ACTIVATE)
			rd_mux = {7'h00, dev_on[state_reg.ldn]};
		else if (cfg_index == IDX_BASE_HI)
			rd_mux = state_reg.base[state_reg.ldn][15:8];
		else if (cfg_index == IDX_BASE_LO)
			rd_mux = state_reg.base[state_reg.ldn][7:0];
		else if (cfg_index == IDX_BASE2_HI)
			rd_mux = state_reg.base2[state_reg.ldn][15:8];
		else if (cfg_index == IDX_BASE2_LO)
			rd_mux = state_reg.base2[state_reg.ldn][7:0];
		else if (cfg_index == IDX_IRQ_SEL)
			rd_mux = {4'h0, state_reg.irq_lvl[state_reg.ldn]};
		else if (cfg_index == IDX_DMA_SEL)
			rd_mux = {5'h00, state_reg.dma_sel[state_reg.ldn]};
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg.ldn    <= 3'h0;
			state_reg.active <= '0;
			for (int i = 0; i < NUM_LDEV; i++)
			begin
				state_reg.base[i]    <= BASE_RESET;
				state_reg.base2[i]   <= BASE_RESET;
				state_reg.irq_lvl[i] <= IRQ_SEL_RESET[3:0];
				state_reg.dma_sel[i] <= DMA_SEL_RESET[2:0];
			end
			cfg_rdata        <= 8'h00;
		end
		else
		begin
			state_reg <= state_next;
			cfg_rdata <= (cfg_rd && cfg_state) ? rd_mux : 8'h00;
		end
	end

	// Standby reset only; main reset leaves this one alone
	always_ff @(posedge ref_clk or negedge standby_por_n)
	begin
		if (!standby_por_n)
			uart2_act_reg <= 1'b0;
		else
			uart2_act_reg <= uart2_act_next;
	end

	// Address decode, gated by activity and valid base, keyboard by activity only
	always_comb
	begin
		io_select  = 8'h00;
		ecp_select = 1'b0;
		if (io_strobe)
		begin
			for (int i = 0; i < NUM_LDEV; i++)
				if ((i == LDN_FLOPPY || i == LDN_UART1 || i == LDN_UART2)
					&& dev_on[i] && win8_ok(state_reg.base[i])
					&& hit8(state_reg.base[i], io_addr))
					io_select[i] = 1'b1;
			if (dev_on[LDN_UART2] && win8_ok(state_reg.base2[LDN_UART2])
				&& hit8(state_reg.base2[LDN_UART2], io_addr))
				io_select[LDN_UART2] = 1'b1;
			if (dev_on[LDN_PARPORT] && par_ok)
			begin
				if (par8 ? hit8(state_reg.base[LDN_PARPORT], io_addr)
					: (io_addr[11:2] == state_reg.base[LDN_PARPORT][11:2]))
					io_select[LDN_PARPORT] = 1'b1;
				if (io_addr >= state_reg.base[LDN_PARPORT][11:0] + ECP_OFS
					&& io_addr <= state_reg.base[LDN_PARPORT][11:0]
						+ ECP_OFS + 12'h002)
					ecp_select = 1'b1;
			end
			if (dev_on[LDN_KEYBOARD]
				&& (io_addr == KBD_DATA_ADDR || io_addr == KBD_CMD_ADDR))
				io_select[LDN_KEYBOARD] = 1'b1;
		end
	end

	// Per-unit interrupt and DMA qualification
	always_comb
	begin
		dev_irq = '0;
		dev_dma = '0;
		dev_irq[LDN_FLOPPY]   = floppy_dma_irq_enable;
		dev_irq[LDN_PARPORT]  = parport_irq_enable
			&& !(parport_mode == PMODE_ECP && ecp_service_interrupt_bit);
		dev_irq[LDN_UART1]    = (|uart1_ier_bits) && uart1_aux_output_two;
		dev_irq[LDN_UART2]    = (|uart2_ier_bits) && uart2_aux_output_two;
		dev_irq[LDN_KEYBOARD] = 1'b1;
		dev_dma[LDN_FLOPPY]   = floppy_dma_irq_enable;
		dev_dma[LDN_PARPORT]  = ecp_dma_enable_bit
			&& parport_mode == PMODE_ECP;
		dev_dma[LDN_UART2]    = uart2_dma_enable;
	end

	// Routing to the shared pins; undriven pins float
	always_comb
	begin
		irq_out                 = 16'h0000;
		irq_oe                  = 16'h0000;
		system_mgmt_interrupt_n = 1'b1;
		dma_request_pin         = '0;
		dma_request_oe          = '0;
		for (int i = 0; i < NUM_LDEV; i++)
		begin
			if (dev_on[i] && dev_irq[i] && state_reg.irq_lvl[i] != 4'h0
				&& (serial_irq_mode
					|| PAR_IRQ_MASK[state_reg.irq_lvl[i]]))
			begin
				irq_oe[state_reg.irq_lvl[i]]  = 1'b1;
				irq_out[state_reg.irq_lvl[i]] = unit_irq[i];
			end
			if (dev_on[i] && dev_dma[i] && state_reg.dma_sel[i] >= 3'h1
				&& state_reg.dma_sel[i] <= 3'h3)
			begin
				dma_request_oe[state_reg.dma_sel[i][1:0]]  = 1'b1;
				dma_request_pin[state_reg.dma_sel[i][1:0]] = unit_dma_req[i];
			end
		end
		// Shared line: host must switch mgmt off before using IRQ2
		if (mgmt_irq_enable)
		begin
			irq_oe[IRQ_SHARED]      = 1'b0;
			system_mgmt_interrupt_n = ~unit_irq[LDN_FLOPPY];
		end
	end

	chk_dma_zero_float: assert property (@(posedge ref_clk)
		disable iff (!nrst)
		(state_reg.dma_sel[LDN_FLOPPY][1:0] == 2'h0
		&& state_reg.dma_sel[LDN_PARPORT][1:0] == 2'h0
		&& state_reg.dma_sel[LDN_UART2][1:0] == 2'h0)
		|-> dma_request_oe == '0)
		else $error("dma pin driven with no channel");
	chk_irq_zero_idle: assert property (@(posedge ref_clk)
		disable iff (!nrst)
		(dev_on == '0) |-> (irq_oe == 16'h0000 && dma_request_oe == '0))
		else $error("pin driven with all devices off");
	chk_write_takes: assert property (@(posedge ref_clk)
		disable iff (!nrst) (wr_ok && cfg_index == IDX_IRQ_SEL) |=>
		state_reg.irq_lvl[$past(state_reg.ldn)] == $past(cfg_wdata[3:0]))
		else $error("irq level write lost");
	chk_no_cfg_write: assert property (@(posedge ref_clk)
		disable iff (!nrst) (!cfg_state) |=> state_reg == $past(state_reg))
		else $error("bank changed outside config state");
	chk_kbd_fixed: assert property (@(posedge ref_clk)
		disable iff (!nrst) io_select[LDN_KEYBOARD] |->
		(io_addr == KBD_DATA_ADDR || io_addr == KBD_CMD_ADDR))
		else $error("keyboard decoded at wrong address");
	chk_floppy_range: assert property (@(posedge ref_clk)
		disable iff (!nrst) io_select[LDN_FLOPPY] |->
		(win8_ok(state_reg.base[LDN_FLOPPY]) && dev_on[LDN_FLOPPY]))
		else $error("floppy decoded with bad base");
	chk_par_mask: assert property (@(posedge ref_clk)
		disable iff (!nrst)
		!serial_irq_mode |-> (irq_oe & ~PAR_IRQ_MASK) == 16'h0000)
		else $error("unavailable irq driven");
	// Only the floppy raises a request here, so any high pin is a leak
	chk_floppy_irq_gate: assert property (@(posedge ref_clk)
		disable iff (!nrst)
		(!floppy_dma_irq_enable && unit_irq == 8'h01)
		|-> irq_out == 16'h0000)
		else $error("floppy irq without dma bit");
	chk_epp_align: assert property (@(posedge ref_clk)
		disable iff (!nrst)
		epp_allowed |-> state_reg.base[LDN_PARPORT][2:0] == 3'h0)
		else $error("epp offered on four-byte base");
	chk_mgmt_idle: assert property (@(posedge ref_clk)
		disable iff (!nrst) !mgmt_irq_enable |-> system_mgmt_interrupt_n)
		else $error("mgmt output low while disabled");
	chk_irq2_shared: assert property (@(posedge ref_clk)
		disable iff (!nrst) mgmt_irq_enable |-> !irq_oe[IRQ_SHARED])
		else $error("shared line driven in mgmt mode");
	chk_dma_gate: assert property (@(posedge ref_clk)
		disable iff (!nrst)
		(!floppy_dma_irq_enable && !ecp_dma_enable_bit && !uart2_dma_enable)
		|-> dma_request_oe == '0)
		else $error("dma pin driven with unit disabled");
	chk_base2_refused: assert property (@(posedge ref_clk)
		disable iff (!nrst)
		(wr_ok && cfg_index == IDX_BASE2_HI && state_reg.ldn != LDN_UART2)
		|=> $stable(state_reg.base2))
		else $error("second base written for wrong device");
	chk_uart2_standby: assert property (@(posedge ref_clk)
		disable iff (!nrst) !standby_por_n |=> !uart2_act_reg)
		else $error("serial 2 activate survived standby reset");
endmodule // ldev_cfg

//--- testbench/ldev_host_model.sv
// Interrupt and DMA controller side: resolves the request lines it sees
`timescale 1ns/10ps
module ldev_host_model (
	input  wire logic [15:0] irq_out,
	input  wire logic [15:0] irq_oe,
	input  wire logic [3:1]  dma_pin,
	input  wire logic [3:1]  dma_oe,
	output logic      [15:0] irq_line,
	output logic      [3:1]  dreq_line
);
	// Released lines fall to the board pull-downs, never hold a stale value
	always_comb
	begin
		for (int n = 0; n < 16; n++)
			irq_line[n] = irq_oe[n] ? irq_out[n] : 1'b0;
		for (int n = 1; n < 4; n++)
			dreq_line[n] = dma_oe[n] ? dma_pin[n] : 1'b0;
	end
endmodule // ldev_host_model

//--- testbench/logical_device_resource_config_bench.sv
// Self-checking bench for the logical device configuration bank
`timescale 1ns/10ps
module logical_device_resource_config_bench;
	import ldev_cfg_pkg::*;
	logic        ref_clk = 0, nrst = 0, standby_por_n = 0, cfg_state = 1;
	logic        cfg_wr = 0, cfg_rd = 0, io_strobe = 1;
	logic        serial_irq_mode = 0, mgmt_irq_enable = 0;
	logic        floppy_dma_irq_enable = 0, parport_irq_enable = 0;
	logic        ecp_service_interrupt_bit = 0, ecp_dma_enable_bit = 0;
	logic        uart1_aux_output_two = 0, uart2_aux_output_two = 0;
	logic        uart2_dma_enable = 0, ecp_select, epp_allowed;
	logic        system_mgmt_interrupt_n;
	logic [2:0]  parport_mode = 0;
	logic [3:0]  uart1_ier_bits = 0, uart2_ier_bits = 0;
	logic [7:0]  cfg_index = 0, cfg_wdata = 0, unit_irq = 0, unit_dma_req = 0;
	logic [7:0]  cfg_rdata, io_select;
	logic [11:0] io_addr = 0;
	logic [15:0] irq_out, irq_oe, irq_line, e;
	logic [3:1]  dma_request_pin, dma_request_oe, dreq_line;
	int          bad_count = 0, n_checks = 0, cyc = 0, b, seed = 32'h5930CC54;
	int          act[8], base[8];

	ldev_cfg ldev_cfg_inst (.ref_clk(ref_clk), .nrst(nrst),
		.standby_por_n(standby_por_n), .cfg_state(cfg_state), .cfg_wr(cfg_wr),
		.cfg_rd(cfg_rd), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .io_addr(io_addr), .io_strobe(io_strobe),
		.io_select(io_select), .ecp_select(ecp_select),
		.epp_allowed(epp_allowed), .serial_irq_mode(serial_irq_mode),
		.mgmt_irq_enable(mgmt_irq_enable), .unit_irq(unit_irq),
		.unit_dma_req(unit_dma_req),
		.floppy_dma_irq_enable(floppy_dma_irq_enable),
		.parport_irq_enable(parport_irq_enable),
		.ecp_service_interrupt_bit(ecp_service_interrupt_bit),
		.ecp_dma_enable_bit(ecp_dma_enable_bit), .parport_mode(parport_mode),
		.uart1_ier_bits(uart1_ier_bits),
		.uart1_aux_output_two(uart1_aux_output_two),
		.uart2_ier_bits(uart2_ier_bits),
		.uart2_aux_output_two(uart2_aux_output_two),
		.uart2_dma_enable(uart2_dma_enable), .irq_out(irq_out),
		.irq_oe(irq_oe), .system_mgmt_interrupt_n(system_mgmt_interrupt_n),
		.dma_request_pin(dma_request_pin), .dma_request_oe(dma_request_oe));
	ldev_host_model ldev_host_model_inst (.irq_out(irq_out), .irq_oe(irq_oe),
		.dma_pin(dma_request_pin), .dma_oe(dma_request_oe),
		.irq_line(irq_line), .dreq_line(dreq_line));

	initial
	begin
		forever #4 ref_clk = ~ref_clk;
	end
	// Whole run is a few hundred cycles; this only cuts a hang short
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			print_verdict();
		end
	end

	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task check(input string what, input logic [15:0] seen, exp);
		n_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task step;
		@(posedge ref_clk);
		#1;
	endtask
	// An idle cycle between writes keeps each strobe edge distinct
	task wr(input logic [7:0] i, d);
		step;
		cfg_wr = 1;
		cfg_index = i;
		cfg_wdata = d;
		step;
		cfg_wr = 0;
	endtask
	task rd(input logic [7:0] i, e8, input string what);
		step;
		cfg_rd = 1;
		cfg_index = i;
		step;
		cfg_rd = 0;
		check(what, {8'h00, cfg_rdata}, {8'h00, e8});
	endtask
	task setdev(input int d, bb);
		wr(8'h07, d[7:0]);
		wr(8'h60, bb[15:8]);
		wr(8'h61, bb[7:0]);
		wr(8'h30, 8'h01);
		base[d] = bb;
		act[d] = 1;
	endtask
	function automatic logic exp_sel(input int d, a);
		int bb = base[d];
		int lim = (d == 3) ? 32'hFFC : 32'hFF8;
		int al = (d == 3) ? 4 : 8;
		int len = (d == 3 && bb % 8 != 0) ? 4 : 8;
		if (act[d] == 0)
			return 0;
		if (d == 7)
			return a == 32'h60 || a == 32'h64;
		if (bb < 32'h100 || bb > lim || bb % al != 0)
			return 0;
		return a >= bb && a < bb + len;
	endfunction
	task probe(input int d, a);
		io_addr = a[11:0];
		step;
		check("io_select", {15'h0, io_select[d]}, {15'h0, exp_sel(d, a)});
	endtask

	initial
	begin
		act = '{default: 0};
		base = '{default: 0};
		repeat (16) @(posedge ref_clk);
		#1;
		nrst = 1;
		standby_por_n = 1;
		rd(8'h70, 8'h00, "irq_level");
		rd(8'h74, 8'h04, "dma_channel");
		rd(8'h60, 8'h00, "base_high");
		check("irq_oe", irq_oe, 16'h0000);
		$display("reset defaults test done");
		b = 32'h100 + 8 * (($random(seed) & 32'h7FFFFFFF) % 480);
		setdev(4, b);
		for (int k = -1; k < 9; k++)
			probe(4, b + k);
		setdev(4, 32'h0F8);
		probe(4, 32'h0F8);
		setdev(4, 32'h104);
		probe(4, 32'h104);
		setdev(3, 32'h27C);
		probe(3, 32'h27F);
		probe(3, 32'h280);
		check("epp_allowed", {15'h0, epp_allowed}, 16'h0000);
		setdev(3, 32'h278);
		check("epp_allowed", {15'h0, epp_allowed}, 16'h0001);
		for (int k = 32'h3FF; k < 32'h404; k++)
		begin
			io_addr = 12'h278 + k[11:0];
			step;
			e = (k >= 32'h400 && k <= 32'h402) ? 16'h0001 : 16'h0000;
			check("ecp_select", {15'h0, ecp_select}, e);
		end
		setdev(7, 0);
		for (int a = 32'h5F; a < 32'h66; a++)
			probe(7, a);
		wr(8'h30, 8'h00);
		act[7] = 0;
		probe(7, 32'h60);
		rd(8'h30, 8'h00, "activate");
		cfg_state = 0;
		wr(8'h30, 8'h01);
		cfg_state = 1;
		rd(8'h30, 8'h00, "activate");
		$display("decode test done");
		wr(8'h07, 8'h05);
		wr(8'h30, 8'h01);
		nrst = 0;
		step;
		nrst = 1;
		act = '{5: 1, default: 0};
		base = '{default: 0};
		wr(8'h07, 8'h05);
		rd(8'h30, 8'h01, "serial2_activate");
		wr(8'h62, 8'h02);
		wr(8'h63, 8'hE8);
		io_addr = 12'h2EC;
		step;
		check("serial2_window", {15'h0, io_select[5]}, 16'h0001);
		standby_por_n = 0;
		step;
		standby_por_n = 1;
		rd(8'h30, 8'h00, "serial2_activate");
		$display("reset domain test done");
		setdev(4, 32'h3F8);
		wr(8'h62, 8'h02);
		rd(8'h62, 8'h00, "base2_refused");
		unit_irq = 8'h10;
		uart1_aux_output_two = 1;
		// Management interrupt stays disabled while IRQ2 may be chosen
		mgmt_irq_enable = 0;
		for (int m = 0; m < 2; m++)
			for (int lv = 0; lv < 16; lv++)
			begin
				serial_irq_mode = m[0];
				uart1_ier_bits = 4'h1 << (lv % 4);
				wr(8'h70, lv[7:0]);
				e = (lv != 0 && (m == 1 || PAR_IRQ_MASK[lv])) ? 16'h1 << lv : 0;
				check("irq_oe", irq_oe, e);
				check("irq_line", irq_line, e);
			end
		uart1_aux_output_two = 0;
		step;
		check("irq_oe", irq_oe, 16'h0000);
		setdev(0, 32'h3F0);
		wr(8'h70, 8'h06);
		unit_irq = 8'h01;
		step;
		check("irq_oe", irq_oe, 16'h0000);
		floppy_dma_irq_enable = 1;
		step;
		check("irq_line", irq_line, 16'h0040);
		mgmt_irq_enable = 1;
		step;
		check("mgmt_n", {15'h0, system_mgmt_interrupt_n}, 16'h0000);
		mgmt_irq_enable = 0;
		setdev(3, 32'h278);
		wr(8'h70, 8'h05);
		wr(8'h74, 8'h03);
		unit_irq = 8'h08;
		unit_dma_req = 8'h08;
		parport_mode = PMODE_ECP;
		step;
		check("par_irq", {15'h0, irq_oe[5]}, 16'h0000);
		check("par_dma", {13'h0, dma_request_oe}, 16'h0000);
		parport_irq_enable = 1;
		ecp_dma_enable_bit = 1;
		step;
		check("par_irq", {15'h0, irq_line[5]}, 16'h0001);
		check("par_dma", {13'h0, dreq_line}, 16'h0004);
		ecp_service_interrupt_bit = 1;
		parport_mode = 3'h0;
		step;
		check("par_irq", {15'h0, irq_oe[5]}, 16'h0001);
		check("par_dma", {13'h0, dma_request_oe}, 16'h0000);
		parport_mode = PMODE_ECP;
		step;
		check("par_irq", {15'h0, irq_oe[5]}, 16'h0000);
		ecp_dma_enable_bit = 0;
		wr(8'h74, 8'h04);
		wr(8'h07, 8'h00);
		$display("interrupt test done");
		unit_dma_req = 8'h01;
		for (int c = 0; c < 8; c++)
		begin
			wr(8'h74, c[7:0]);
			e = (c >= 1 && c <= 3) ? 16'h1 << (c - 1) : 0;
			check("dma_oe", {13'h0, dma_request_oe}, e);
			check("dreq_line", {13'h0, dreq_line}, e);
		end
		wr(8'h74, 8'h02);
		floppy_dma_irq_enable = 0;
		step;
		check("dma_oe", {13'h0, dma_request_oe}, 16'h0000);
		$display("dma test done");
		print_verdict();
	end
endmodule // logical_device_resource_config_bench
